// ---- i2c_pkg.sv ----
// Purpose: shared constants for the two-wire master controller
// Assumes: 32-bit apb words, 16 mhz function clock on the link side
// Notes:   counts are in function clock cycles
package i2c_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] CON_OFS    = 12'h000;
  localparam logic [11:0] TAR_OFS    = 12'h004;
  localparam logic [11:0] DATA_OFS   = 12'h010;
  localparam logic [11:0] SSH_OFS    = 12'h014;
  localparam logic [11:0] SSL_OFS    = 12'h018;
  localparam logic [11:0] FSH_OFS    = 12'h01C;
  localparam logic [11:0] FSL_OFS    = 12'h020;
  localparam logic [11:0] EN_OFS     = 12'h06C;
  localparam logic [11:0] STAT_OFS   = 12'h070;
  localparam logic [11:0] DMA_OFS    = 12'h088;
  // ==========================================================
  // field positions
  localparam int CON_MASTER  = 0;
  localparam int TAR_WIDE    = 12;
  localparam int TAR_SPECIAL = 11;
  localparam int TAR_SBYTE   = 10;
  localparam int CMD_READ    = 8;
  localparam int ST_ACT      = 0;
  localparam int ST_TNF      = 1;
  localparam int ST_TFE      = 2;
  localparam int ST_RNE      = 3;
  localparam int ST_MACT     = 5;
  localparam int DMA_TX      = 0;
  localparam int DMA_RX      = 1;
  localparam logic [1:0] SPEED_FAST = 2'h2;
  // ==========================================================
  // reset values
  localparam logic [3:0]  CON_RST = 4'h3;
  localparam logic [12:0] TAR_RST = 13'h0055;
  // ==========================================================
  // scl phase timing, rounded up to whole function clock cycles
  localparam int FCLK_MHZ   = 16;
  localparam int STD_HI_NS  = 4000;
  localparam int STD_LO_NS  = 4700;
  localparam int FAST_HI_NS = 600;
  localparam int FAST_LO_NS = 1300;
  localparam logic [15:0] SSH_RST = 16'((STD_HI_NS * FCLK_MHZ + 999) / 1000);
  localparam logic [15:0] SSL_RST = 16'((STD_LO_NS * FCLK_MHZ + 999) / 1000);
  localparam logic [15:0] FSH_RST = 16'((FAST_HI_NS * FCLK_MHZ + 999) / 1000);
  localparam logic [15:0] FSL_RST = 16'((FAST_LO_NS * FCLK_MHZ + 999) / 1000);
endpackage : i2c_pkg

// ---- xfer_if.sv ----
// Purpose: byte operation handshake between register side and bit engine
// Assumes: op fields stay stable from a req toggle until the matching ack
// Notes:   toggles are synchronised at each receiving end
`timescale 1ns/1ps
interface xfer_if;
  logic        req_tgl;
  logic        op_start;
  logic        op_stop;
  logic        op_rd;
  logic [7:0]  op_data;
  logic [15:0] op_hcnt;
  logic [15:0] op_lcnt;
  logic        ack_tgl;
  logic [7:0]  rx_byte;
  logic        rx_nack;
  modport ctl (output req_tgl, op_start, op_stop, op_rd, op_data, op_hcnt, op_lcnt,
               input ack_tgl, rx_byte, rx_nack);
  modport eng (input req_tgl, op_start, op_stop, op_rd, op_data, op_hcnt, op_lcnt,
               output ack_tgl, rx_byte, rx_nack);
endinterface : xfer_if

// ---- bit_sync.sv ----
// Purpose: two flip-flop synchroniser for levels
// Assumes: each bit is an independent level or toggle
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  if (W < 1) begin : g_chk
    $error("bit_sync width must be at least 1");
  end
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : bit_sync

// ---- i2c_bit_engine.sv ----
// Purpose: link side engine: start, restart, byte shift, ack, stop
// Assumes: op fields stable while req toggle differs from last seen
// Notes:   no clock stretching or arbitration; slave nack is reported only
`timescale 1ns/1ps
module i2c_bit_engine (
  // link clock and reset
  input  wire logic function_clock,
  input  wire logic rst_n,
  // synchronised inputs
  input  wire logic scl_s,
  input  wire logic sda_s,
  input  wire logic req_s,
  // operation handshake
  xfer_if.eng       xf,
  // open drain pins, released when oe_n is high
  output logic      scl_o,
  output logic      scl_oe_n,
  output logic      sda_o,
  output logic      sda_oe_n
);
  typedef enum logic [2:0] {
    IDLE = 3'h0, RS_LO = 3'h1, RS_HI = 3'h2, STRT = 3'h3,
    B_LO = 3'h4, B_HI = 3'h5, P_LO = 3'h6, P_HI = 3'h7
  } eng_st_t;

  eng_st_t     st_q, st_d;
  logic [15:0] cnt_q, cnt_d, hc_q, hc_d, lc_q, lc_d;
  logic [8:0]  sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  rx_q, rx_d;
  logic        scl_q, scl_d, sda_q, sda_d, held_q, held_d, seen_q, seen_d;
  logic        rd_q, rd_d, stop_q, stop_d, ack_q, ack_d, nack_q, nack_d;

  function automatic logic [15:0] ld(input logic [15:0] v);
    ld = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : ld

  // ==========================================================
  // phase sequencer
  always_comb begin
    st_d = st_q; cnt_d = cnt_q - 16'h0001; hc_d = hc_q; lc_d = lc_q; sh_d = sh_q;
    bit_d = bit_q; rx_d = rx_q; scl_d = scl_q; sda_d = sda_q; held_d = held_q;
    seen_d = seen_q; rd_d = rd_q; stop_d = stop_q; ack_d = ack_q; nack_d = nack_q;
    case (st_q)
      IDLE: begin
        cnt_d = cnt_q;
        if (req_s != seen_q) begin
          seen_d = req_s;
          rd_d   = xf.op_rd;
          stop_d = xf.op_stop;
          hc_d   = xf.op_hcnt;
          lc_d   = xf.op_lcnt;
          sh_d   = xf.op_rd ? 9'h1FF : {xf.op_data, 1'b1};
          bit_d  = 4'h0;
          if (xf.op_start && held_q) begin
            st_d = RS_LO; sda_d = 1'b1; cnt_d = ld(xf.op_lcnt);
          end else if (xf.op_start) begin
            st_d = STRT; sda_d = 1'b0; cnt_d = ld(xf.op_hcnt);
          end else begin
            st_d = B_LO; cnt_d = ld(xf.op_lcnt);
          end
        end
      end
      RS_LO: if (cnt_q == 16'h0000) begin
        st_d = RS_HI; scl_d = 1'b1; cnt_d = ld(hc_q);
      end
      RS_HI: if (cnt_q == 16'h0000) begin
        st_d = STRT; sda_d = 1'b0; cnt_d = ld(hc_q);
      end
      STRT: if (cnt_q == 16'h0000) begin
        st_d = B_LO; scl_d = 1'b0; held_d = 1'b1; cnt_d = ld(lc_q);
      end
      B_LO: begin
        // data changes one cycle after scl falls, for hold time
        sda_d = (bit_q == 4'h8) ? (!rd_q || stop_q) : sh_q[8];
        if (cnt_q == 16'h0000) begin
          st_d = B_HI; scl_d = 1'b1; cnt_d = ld(hc_q);
        end
      end
      B_HI: if (cnt_q == 16'h0000) begin
        sh_d  = {sh_q[7:0], sda_s};
        bit_d = bit_q + 4'h1;
        scl_d = 1'b0;
        cnt_d = ld(lc_q);
        st_d  = B_LO;
        if (bit_q == 4'h8) begin
          rx_d   = sh_q[7:0];
          nack_d = sda_s;
          if (stop_q) begin
            st_d = P_LO;
          end else begin
            st_d = IDLE; ack_d = !ack_q;
          end
        end
      end
      P_LO: begin
        sda_d = 1'b0;
        if (cnt_q == 16'h0000) begin
          st_d = P_HI; scl_d = 1'b1; cnt_d = ld(hc_q);
        end
      end
      P_HI: if (cnt_q == 16'h0000) begin
        st_d = IDLE; sda_d = 1'b1; held_d = 1'b0; ack_d = !ack_q;
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge function_clock) begin
    if (!rst_n) begin
      st_q <= IDLE; cnt_q <= 16'h0000; hc_q <= 16'h0000; lc_q <= 16'h0000;
      sh_q <= 9'h1FF; bit_q <= 4'h0; rx_q <= 8'h00; scl_q <= 1'b1; sda_q <= 1'b1;
      held_q <= 1'b0; seen_q <= 1'b0; rd_q <= 1'b0; stop_q <= 1'b0;
      ack_q <= 1'b0; nack_q <= 1'b0; scl_o <= 1'b0; sda_o <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; hc_q <= hc_d; lc_q <= lc_d; sh_q <= sh_d;
      bit_q <= bit_d; rx_q <= rx_d; scl_q <= scl_d; sda_q <= sda_d;
      held_q <= held_d; seen_q <= seen_d; rd_q <= rd_d; stop_q <= stop_d;
      ack_q <= ack_d; nack_q <= nack_d; scl_o <= 1'b0; sda_o <= 1'b0;
    end
  end

  assign scl_oe_n   = scl_q;
  assign sda_oe_n   = sda_q;
  assign xf.ack_tgl = ack_q;
  assign xf.rx_byte = rx_q;
  assign xf.rx_nack = nack_q;
endmodule : i2c_bit_engine

// ---- i2c_master_control.sv ----
// Purpose: apb register side of a two-wire bus master with command fifo
// Assumes: apb master keeps each request until pready; link engine on function_clock
// Notes:   one wait state on every apb access; single rx holding register
//
// Functional notes
// - while disabled the command fifo is held empty and data writes are dropped.
// - control holds a two-bit speed field at 2:1 that picks the scl phase counts, and slave wide-address bit 3.
// - target holds a 10-bit address at 9:0 and master wide addressing at bit 12.
// - target also selects general call instead of the address, or a start byte ahead of the addressed transfer.
// - a command word is a data byte at 7:0 and a read bit at 8 that voids the byte.
// - queued commands switch between read and write freely, with a repeated start.
// - transfers continue while commands remain; on an empty fifo a stop follows.
// - a command queued after the fifo ran empty opens a new transaction.
// - scl phases are timed in 16 mhz function clock cycles.
// - the dma control bits enable the transmit and receive request lines.
`timescale 1ns/1ps
module i2c_master_control #(
  parameter int TX_DEPTH = 8
) (
  // clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        function_clock,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // dma handshake requests
  output logic             tx_dma_req,
  output logic             rx_dma_req
);
  localparam int AW = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(TX_DEPTH);

  if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_chk
    $error("TX_DEPTH must be a power of two, at least 2");
  end

  xfer_if xf ();

  // ==========================================================
  // clock crossings
  logic       ack_s;
  logic [3:0] lnk_s;

  bit_sync #(.W(1)) u_ack_sync (
    .clk (ref_clk),
    .d   (xf.ack_tgl),
    .q   (ack_s)
  );

  // reset, pins and request toggle into the link domain
  bit_sync #(.W(4)) u_lnk_sync (
    .clk (function_clock),
    .d   ({rstn, scl_i, sda_i, xf.req_tgl}),
    .q   (lnk_s)
  );

  i2c_bit_engine u_engine (
    .function_clock (function_clock),
    .rst_n          (lnk_s[3]),
    .scl_s          (lnk_s[2]),
    .sda_s          (lnk_s[1]),
    .req_s          (lnk_s[0]),
    .xf             (xf),
    .scl_o          (scl_o),
    .scl_oe_n       (scl_oe_n),
    .sda_o          (sda_o),
    .sda_oe_n       (sda_oe_n)
  );

  // ==========================================================
  // register file and apb slave
  logic [3:0]  con_q, con_d;
  logic [12:0] tar_q, tar_d;
  logic        en_q, en_d;
  logic [15:0] ssh_q, ssh_d, ssl_q, ssl_d, fsh_q, fsh_d, fsl_q, fsl_d;
  logic [1:0]  dma_q, dma_d;
  logic [31:0] prdata_q, prdata_d, rmux;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, hit;
  logic        wr_done, rd_done, txr_q, txr_d, rxr_q, rxr_d;
  logic [AW:0] cnt_q;
  logic        open_q, infl_q, rxv_q, mact;
  logic [7:0]  rx_q;

  assign mact    = open_q || infl_q;
  assign wr_done = psel && penable && pready_q && pwrite && !pslverr_q;
  assign rd_done = psel && penable && pready_q && !pwrite && !pslverr_q;

  always_comb begin
    hit  = 1'b1;
    rmux = 32'h0000_0000;
    case (paddr)
      i2c_pkg::CON_OFS:  rmux[3:0]   = con_q;
      i2c_pkg::TAR_OFS:  rmux[12:0]  = tar_q;
      i2c_pkg::DATA_OFS: rmux[7:0]   = rx_q;
      i2c_pkg::SSH_OFS:  rmux[15:0]  = ssh_q;
      i2c_pkg::SSL_OFS:  rmux[15:0]  = ssl_q;
      i2c_pkg::FSH_OFS:  rmux[15:0]  = fsh_q;
      i2c_pkg::FSL_OFS:  rmux[15:0]  = fsl_q;
      i2c_pkg::EN_OFS:   rmux[0]     = en_q;
      i2c_pkg::DMA_OFS:  rmux[1:0]   = dma_q;
      i2c_pkg::STAT_OFS: begin
        rmux[i2c_pkg::ST_ACT]  = mact;
        rmux[i2c_pkg::ST_TNF]  = cnt_q != FULL;
        rmux[i2c_pkg::ST_TFE]  = cnt_q == '0;
        rmux[i2c_pkg::ST_RNE]  = rxv_q;
        rmux[i2c_pkg::ST_MACT] = mact;
      end
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    con_d = con_q; tar_d = tar_q; en_d = en_q; dma_d = dma_q;
    ssh_d = ssh_q; ssl_d = ssl_q; fsh_d = fsh_q; fsl_d = fsl_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    pready_d  = psel && penable && !pready_q;
    if (psel && penable && !pready_q) begin
      prdata_d  = pwrite ? 32'h0000_0000 : rmux;
      pslverr_d = !hit;
    end
    if (wr_done) begin
      case (paddr)
        i2c_pkg::CON_OFS: con_d = pwdata[3:0];
        i2c_pkg::TAR_OFS:
          if (!en_q || (con_q[i2c_pkg::CON_MASTER] && !mact && cnt_q == '0)) begin
            tar_d = pwdata[12:0];
          end
        i2c_pkg::SSH_OFS: ssh_d = pwdata[15:0];
        i2c_pkg::SSL_OFS: ssl_d = pwdata[15:0];
        i2c_pkg::FSH_OFS: fsh_d = pwdata[15:0];
        i2c_pkg::FSL_OFS: fsl_d = pwdata[15:0];
        i2c_pkg::EN_OFS:  en_d  = pwdata[0];
        i2c_pkg::DMA_OFS: dma_d = pwdata[1:0];
        default: ;
      endcase
    end
    txr_d = dma_q[i2c_pkg::DMA_TX] && en_q && cnt_q != FULL;
    rxr_d = dma_q[i2c_pkg::DMA_RX] && rxv_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      con_q <= i2c_pkg::CON_RST; tar_q <= i2c_pkg::TAR_RST; en_q <= 1'b0;
      ssh_q <= i2c_pkg::SSH_RST; ssl_q <= i2c_pkg::SSL_RST;
      fsh_q <= i2c_pkg::FSH_RST; fsl_q <= i2c_pkg::FSL_RST;
      dma_q <= 2'h0; prdata_q <= 32'h0000_0000; pready_q <= 1'b0;
      pslverr_q <= 1'b0; txr_q <= 1'b0; rxr_q <= 1'b0;
    end else begin
      con_q <= con_d; tar_q <= tar_d; en_q <= en_d;
      ssh_q <= ssh_d; ssl_q <= ssl_d; fsh_q <= fsh_d; fsl_q <= fsl_d;
      dma_q <= dma_d; prdata_q <= prdata_d; pready_q <= pready_d;
      pslverr_q <= pslverr_d; txr_q <= txr_d; rxr_q <= rxr_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign tx_dma_req = txr_q;
  assign rx_dma_req = rxr_q;

  // ==========================================================
  // command fifo and transaction sequencer
  logic [8:0]    mem [TX_DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_d;
  logic          push, pop, ack_ev, head_rd;
  logic          open_d, infl_d, rxv_d, dir_q, dir_d, req_q, req_d, seen_q;
  logic [7:0]    rx_d, hb;
  logic [1:0]    hi_q, hi_d, hn;
  logic          hs, ost_q, ost_d, osp_q, osp_d, ord_q, ord_d, odat_q, odat_d;
  logic [7:0]    obyte_q, obyte_d;
  logic [15:0]   ohc_q, ohc_d, olc_q, olc_d;
  logic [1:0]    a98;

  assign head_rd = mem[rp_q][i2c_pkg::CMD_READ];
  assign ack_ev  = ack_s != seen_q;
  assign a98     = tar_q[9:8];

  // header byte for index hi_q: address phase ahead of a command
  always_comb begin
    hn = 2'h1;
    hs = 1'b1;
    hb = {tar_q[6:0], head_rd};
    if (tar_q[i2c_pkg::TAR_SPECIAL]) begin
      if (!tar_q[i2c_pkg::TAR_SBYTE]) begin
        hb = 8'h00;
      end else begin
        hn = 2'h2;
        hb = (hi_q == 2'h0) ? 8'h01 : {tar_q[6:0], head_rd};
      end
    end else if (tar_q[i2c_pkg::TAR_WIDE]) begin
      hn = head_rd ? 2'h3 : 2'h2;
      hs = hi_q != 2'h1;
      case (hi_q)
        2'h0:    hb = {5'h1E, a98, 1'b0};
        2'h1:    hb = tar_q[7:0];
        default: hb = {5'h1E, a98, 1'b1};
      endcase
    end
  end

  always_comb begin
    wp_d = wp_q; rp_d = rp_q; cnt_d = cnt_q; open_d = open_q; infl_d = infl_q;
    rxv_d = rxv_q; rx_d = rx_q; dir_d = dir_q; req_d = req_q; hi_d = hi_q;
    ost_d = ost_q; osp_d = osp_q; ord_d = ord_q; odat_d = odat_q;
    obyte_d = obyte_q; ohc_d = ohc_q; olc_d = olc_q; pop = 1'b0;
    push = wr_done && paddr == i2c_pkg::DATA_OFS && en_q && cnt_q != FULL;
    if (rd_done && paddr == i2c_pkg::DATA_OFS) begin
      rxv_d = 1'b0;
    end
    if (ack_ev) begin
      infl_d = 1'b0;
      if (osp_q) begin
        open_d = 1'b0;
      end
      if (odat_q && ord_q) begin
        rx_d  = xf.rx_byte;
        rxv_d = 1'b1;
      end
    end
    if (en_q && !infl_q && !ack_ev && cnt_q != '0) begin
      infl_d = 1'b1;
      req_d  = !req_q;
      ohc_d  = (con_q[2:1] >= i2c_pkg::SPEED_FAST) ? fsh_q : ssh_q;
      olc_d  = (con_q[2:1] >= i2c_pkg::SPEED_FAST) ? fsl_q : ssl_q;
      if ((hi_q != 2'h0 || !open_q || head_rd != dir_q) && hi_q < hn) begin
        ost_d = hs; osp_d = 1'b0; ord_d = 1'b0; odat_d = 1'b0;
        obyte_d = hb; hi_d = hi_q + 2'h1; open_d = 1'b1;
      end else begin
        pop = 1'b1;
        ost_d = 1'b0; ord_d = head_rd; odat_d = 1'b1; obyte_d = mem[rp_q][7:0];
        osp_d = cnt_q == (AW+1)'(1);
        hi_d = 2'h0; dir_d = head_rd; rp_d = rp_q + 1'b1;
      end
    end
    if (push) begin
      wp_d = wp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (!en_q) begin
      wp_d = '0; rp_d = '0; cnt_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_q] <= pwdata[8:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wp_q <= '0; rp_q <= '0; cnt_q <= '0; open_q <= 1'b0; infl_q <= 1'b0;
      rxv_q <= 1'b0; rx_q <= 8'h00; dir_q <= 1'b0; req_q <= 1'b0; hi_q <= 2'h0;
      seen_q <= 1'b0; ost_q <= 1'b0; osp_q <= 1'b0; ord_q <= 1'b0; odat_q <= 1'b0;
      obyte_q <= 8'h00; ohc_q <= 16'h0000; olc_q <= 16'h0000;
    end else begin
      wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d; open_q <= open_d; infl_q <= infl_d;
      rxv_q <= rxv_d; rx_q <= rx_d; dir_q <= dir_d; req_q <= req_d; hi_q <= hi_d;
      seen_q <= ack_s; ost_q <= ost_d; osp_q <= osp_d; ord_q <= ord_d;
      odat_q <= odat_d; obyte_q <= obyte_d; ohc_q <= ohc_d; olc_q <= olc_d;
    end
  end

  assign xf.req_tgl  = req_q;
  assign xf.op_start = ost_q;
  assign xf.op_stop  = osp_q;
  assign xf.op_rd    = ord_q;
  assign xf.op_data  = obyte_q;
  assign xf.op_hcnt  = ohc_q;
  assign xf.op_lcnt  = olc_q;
endmodule : i2c_master_control

// ---- i2c_master_control_checker.sv ----
// Purpose: port level checks for the two-wire master controller
// Assumes: apb master holds each request until pready
// Notes:   enable state is tracked from completed register writes
`timescale 1ns/1ps
module i2c_master_control_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // dma requests
  input wire logic        tx_dma_req,
  input wire logic        rx_dma_req
);
  // ==========================================================
  // helpers
  logic acc, done, rd, mapped, en_q, en_qq;
  assign acc = psel && penable;
  assign done = acc && pready;
  assign rd = done && !pwrite;
  assign mapped = paddr inside {i2c_pkg::CON_OFS, i2c_pkg::TAR_OFS, i2c_pkg::DATA_OFS,
    i2c_pkg::SSH_OFS, i2c_pkg::SSL_OFS, i2c_pkg::FSH_OFS, i2c_pkg::FSL_OFS,
    i2c_pkg::EN_OFS, i2c_pkg::STAT_OFS, i2c_pkg::DMA_OFS};
  // two stages so the registered request has time to follow a disable
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      en_q <= 1'b0;
    end else if (done && pwrite && paddr == i2c_pkg::EN_OFS) begin
      en_q <= pwdata[0];
    end
    en_qq <= rstn && en_q;
  end
  // ==========================================================
  // assertions
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  a_one_wait: assert property (acc && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> acc && $past(acc))
    else $error("pready without a held access");
  a_err_map: assert property (done |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_err_zero: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_con_narrow: assert property (rd && paddr == i2c_pkg::CON_OFS |-> prdata[31:4] == 28'h0)
    else $error("control word upper bits set");
  a_tar_narrow: assert property (rd && paddr == i2c_pkg::TAR_OFS |-> prdata[31:13] == 19'h0)
    else $error("target register upper bits set");
  a_off_empty: assert property (rd && paddr == i2c_pkg::STAT_OFS && !en_q && !en_qq
    |-> prdata[i2c_pkg::ST_TFE]) else $error("fifo not empty while disabled");
  a_txreq_off: assert property (!en_q && !en_qq |-> !tx_dma_req)
    else $error("tx dma request while disabled");
  a_rxreq_off: assert property (done && pwrite && paddr == i2c_pkg::DMA_OFS
    && !pwdata[i2c_pkg::DMA_RX] |-> ##2 !rx_dma_req) else $error("rx dma request stays");
endmodule : i2c_master_control_checker
bind i2c_master_control i2c_master_control_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_dma_req(tx_dma_req),
  .rx_dma_req(rx_dma_req));

// ---- i2c_slave_model.sv ----
// Purpose: behavioural slave on the two-wire bus
// Assumes: 7-bit or 10-bit write address, reads answered from a counter
// Notes:   acks every byte it receives, stops sending on master nack
`timescale 1ns/1ps
module i2c_slave_model (
  // bus lines
  input wire logic  scl,
  input wire logic  sda,
  // open drain pull, observed bytes and frame counts
  output logic       pull,
  output logic [7:0] rx_byte,
  output logic       rx_stb,
  output int         starts,
  output int         stops
);
  // ==========================================================
  // bit tracking
  logic [7:0] sh, tx;
  logic       rd, first;
  int         bitn;
  initial begin
    pull = 1'b0;
    rx_stb = 1'b0;
    starts = 0;
    stops = 0;
    tx = 8'h5A;
    rd = 1'b0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    starts++;
    bitn = -1;
    first = 1'b1;
    rd = 1'b0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) stops++;
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd && sda) rd = 1'b0;
  end
  always @(negedge scl) begin
    rx_stb = 1'b0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 8 && !rd) begin
      pull = 1'b1;
      rx_byte = sh;
      rx_stb = 1'b1;
      if (first) rd = sh[0];
      first = 1'b0;
    end else if (rd && bitn < 8) begin
      pull = !tx[7-bitn];
    end else begin
      pull = 1'b0;
      if (rd) tx = tx + 8'h01;
    end
  end
endmodule : i2c_slave_model

// ---- i2c_master_control_tb_top.sv ----
// Purpose: self-checking bench for the two-wire master controller
// Assumes: apb master waits on pready, slave model on the pins
// Notes:   expected apb answers and wire bytes are queued by the driver
`timescale 1ns/1ps
module i2c_master_control_tb_top;
  logic        ref_clk, rstn, function_clock, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, tx_dma_req, rx_dma_req;
  logic        scl, sda, pull, rx_stb;
  logic [7:0]  rx_byte, b1, b2, b3;
  logic [6:0]  sa;
  logic [31:0] exp_q[$];
  logic [7:0]  wire_q[$];
  int          starts, stops, st0, sp0, err_total, checks_done;
  localparam logic [31:0] IDLE_ST = 32'((1 << i2c_pkg::ST_TNF) | (1 << i2c_pkg::ST_TFE));
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = ((!sda_oe_n && !sda_o) || pull) ? 1'b0 : 1'b1;

  i2c_master_control i_dut (
    .ref_clk (ref_clk), .rstn (rstn), .function_clock (function_clock),
    .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
    .prdata (prdata), .pready (pready), .pslverr (pslverr),
    .scl_i (scl), .scl_o (scl_o), .scl_oe_n (scl_oe_n),
    .sda_i (sda), .sda_o (sda_o), .sda_oe_n (sda_oe_n),
    .tx_dma_req (tx_dma_req), .rx_dma_req (rx_dma_req)
  );
  i2c_slave_model i_slave (
    .scl (scl), .sda (sda), .pull (pull), .rx_byte (rx_byte), .rx_stb (rx_stb),
    .starts (starts), .stops (stops)
  );

  // ==========================================================
  // clocks
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end
  initial begin
    function_clock = 1'b0;
    #3.3;
    forever #7.5 function_clock = !function_clock;
  end

  // ==========================================================
  // apb master and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // released with an idle edge after each transfer, so no signal is set twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic final_report;
    chk({30'h0, scl_o, sda_o}, 32'h0000_0000);
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // read data is taken at the edge where pready stands high
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk(prdata, exp_q.pop_front());
    end
  end
  always @(posedge rx_stb) begin
    chk({24'h0, rx_byte}, {24'h0, wire_q.pop_front()});
  end

  // ==========================================================
  // scenarios
  initial begin
    seed = 32'h67044323;
    err_total = 0;
    checks_done = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rstn = 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    st0 = starts;
    sp0 = stops;
    sa = 7'($random(seed));
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    b3 = 8'($random(seed));
    rd(i2c_pkg::CON_OFS, 32'(i2c_pkg::CON_RST));
    rd(i2c_pkg::SSH_OFS, 32'(i2c_pkg::SSH_RST));
    rd(i2c_pkg::SSL_OFS, 32'(i2c_pkg::SSL_RST));
    apb(1'b1, i2c_pkg::DATA_OFS, {24'h0, b3});
    rd(i2c_pkg::STAT_OFS, IDLE_ST);
    rd(12'hFFC, 32'h0000_0000);
    $display("test reset done");
    apb(1'b1, i2c_pkg::EN_OFS, 32'h0000_0000);
    apb(1'b1, i2c_pkg::CON_OFS, 32'h0000_0005);
    apb(1'b1, i2c_pkg::FSH_OFS, 32'(i2c_pkg::FSH_RST));
    apb(1'b1, i2c_pkg::FSL_OFS, 32'(i2c_pkg::FSL_RST));
    apb(1'b1, i2c_pkg::TAR_OFS, {25'h0, sa});
    rd(i2c_pkg::CON_OFS, 32'h0000_0005);
    rd(i2c_pkg::TAR_OFS, {25'h0, sa});
    apb(1'b1, i2c_pkg::EN_OFS, 32'h0000_0001);
    $display("test config done");
    wire_q.push_back({sa, 1'b0});
    wire_q.push_back(b1);
    wire_q.push_back(b2);
    apb(1'b1, i2c_pkg::DATA_OFS, {24'h0, b1});
    apb(1'b1, i2c_pkg::DATA_OFS, {24'h0, b2});
    wait (stops == sp0 + 1);
    chk(32'(starts - st0), 32'h0000_0001);
    repeat (20) @(posedge ref_clk);
    rd(i2c_pkg::STAT_OFS, IDLE_ST);
    $display("test write done");
    wire_q.push_back({sa, 1'b0});
    wire_q.push_back(b3);
    wire_q.push_back({sa, 1'b1});
    apb(1'b1, i2c_pkg::DATA_OFS, {24'h0, b3});
    apb(1'b1, i2c_pkg::DATA_OFS, 32'h0000_0100);
    wait (stops == sp0 + 2);
    chk(32'(starts - st0), 32'h0000_0003);
    repeat (20) @(posedge ref_clk);
    rd(i2c_pkg::DATA_OFS, 32'h0000_005A);
    rd(i2c_pkg::STAT_OFS, IDLE_ST);
    $display("test mixed done");
    apb(1'b1, i2c_pkg::DMA_OFS, 32'h0000_0003);
    repeat (3) @(posedge ref_clk);
    chk({30'h0, tx_dma_req, rx_dma_req}, 32'h0000_0002);
    apb(1'b1, i2c_pkg::DMA_OFS, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    chk({30'h0, tx_dma_req, rx_dma_req}, 32'h0000_0000);
    apb(1'b1, i2c_pkg::TAR_OFS, {25'h0, sa ^ 7'h01});
    rd(i2c_pkg::TAR_OFS, {25'h0, sa ^ 7'h01});
    $display("test dma and target done");
    final_report();
  end

  // seven bytes of about 4 us each plus register traffic, with wide slack
  initial begin
    #400000;
    err_total++;
    final_report();
  end
endmodule : i2c_master_control_tb_top
